//--- common/i2s_audio_pkg.sv
// Shared constants and types for the serial audio port
package i2s_audio_pkg;
    // Reference clock and frame figures
    localparam int CLK_HZ = 10_000_000;
    localparam int FRAME_HZ = 48_000;
    localparam int WORD_BITS = 16;
    localparam int FRAME_BITS_NARROW = 32;
    localparam int FRAME_BITS_WIDE = 50;
    localparam int SLAVE_MAX_BCLK_HZ = 3_072_000;
    // Bit clock rates in master mode
    localparam int BCLK_NARROW_HZ = FRAME_HZ * FRAME_BITS_NARROW;
    localparam int BCLK_WIDE_HZ = FRAME_HZ * FRAME_BITS_WIDE;
    // Divider settings: edge rate = CLK_HZ * N / M, two edges per bit
    localparam logic [15:0] DIV_N_NARROW = 16'h0180;
    localparam logic [15:0] DIV_M_NARROW = 16'h04e2;
    localparam logic [15:0] DIV_N_WIDE = 16'h000c;
    localparam logic [15:0] DIV_M_WIDE = 16'h0019;
    // Counter widths and reset values
    localparam int CNT_W = 6;
    localparam int SYNC_STAGES = 3;
    localparam int RX_ALIGN = 2;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [CNT_W-1:0] WORD_CNT = 6'h10;
    localparam logic [CNT_W-1:0] HALF_NARROW = 6'h10;
    localparam logic [CNT_W-1:0] HALF_WIDE = 6'h19;
    localparam logic [CNT_W-1:0] LAST_NARROW = 6'h1f;
    localparam logic [CNT_W-1:0] LAST_WIDE = 6'h31;
    // Sample FIFO shape
    localparam int FIFO_WIDTH = 2 * WORD_BITS;
    localparam int FIFO_DEPTH = 8;
    // Port operating mode
    typedef enum logic [2:0] {
        MODE_OFF = 3'b001,
        MODE_MASTER = 3'b010,
        MODE_SLAVE = 3'b100
    } port_mode_t;
endpackage

//--- common/sample_stream_if.sv
// Valid/ready sample stream between the port and its FIFO
`timescale 1ns/1ps
interface sample_stream_if #(parameter int WIDTH = 32);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- logic/sample_fifo.sv
// Synchronous FIFO holding outgoing stereo sample pairs
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    sample_stream_if.snk wr,
    sample_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic doWr, doRd;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == LAST_PTR) ? '0 : p + 1'b1;
    endfunction

    // Handshakes: honest full and empty
    assign wr.ready = (cnt_reg != DEPTH_CNT);
    assign rd.valid = (cnt_reg != '0);
    assign rd.data = mem[rp_reg];
    assign doWr = wr.valid & wr.ready;
    assign doRd = rd.valid & rd.ready;

    // Pointer and fill level update
    always_comb begin
        wp_next = doWr ? bump(wp_reg) : wp_reg;
        rp_next = doRd ? bump(rp_reg) : rp_reg;
        cnt_next = cnt_reg;
        if (doWr && !doRd) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (doRd && !doWr) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage array, written only
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wp_reg] <= wr.data;
        end
    end
endmodule

//--- logic/i2s_audio_port.sv
// Two-channel serial audio port, master or slave, with transmit FIFO
// Functional notes
// R1: Master drives clock and select; slave receives them
// R2: Serial audio output always driven
// R3: Sixteen-bit words, left MSB at frame MSB
// R4: MSB one bit after select change, falling edge
// R5: Select low left, high right
// R6: Send on falling edge, capture on rising
// R7: Narrow setting: 32 bits per 48 kHz frame
// R8: Wide setting: 50 bits per 48 kHz frame
// R9: Bit clock from fractional N over M divider
// R10: Slave accepts any clock up to 3.072 MHz; here each clock level must last two clk samples to pass the filter
// R11: Master bit clock has fixed duty ratio; here each half lasts a whole number of clocks that varies with the divider
// R12: Pins idle while shared voice function selected
// R13: Extra bit periods send zero, ignore input
`timescale 1ns/1ps
module i2s_audio_port #(
    parameter int FIFO_DEPTH = i2s_audio_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic masterMode,
    input wire logic pcmSelect,
    input wire logic wideFrame,
    input wire logic [15:0] divN,
    input wire logic [15:0] divM,
    input wire logic audioBitClockIn,
    output logic audioBitClockOut,
    output logic audioBitClockOe_n,
    input wire logic channelSelectIn,
    output logic channelSelectOut,
    output logic channelSelectOe_n,
    output logic serialAudioOut,
    input wire logic serialAudioIn,
    input wire logic [31:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic [31:0] rxData,
    output logic rxValid
);
    // Local names for the shared constants
    localparam int W = i2s_audio_pkg::WORD_BITS;
    localparam int FW = i2s_audio_pkg::FIFO_WIDTH;
    localparam int CNT_W = i2s_audio_pkg::CNT_W;
    localparam int SYNC_STAGES = i2s_audio_pkg::SYNC_STAGES;
    localparam int RX_ALIGN = i2s_audio_pkg::RX_ALIGN;
    localparam logic [CNT_W-1:0] CNT_ZERO = i2s_audio_pkg::CNT_ZERO;
    localparam logic [CNT_W-1:0] CNT_ONE = i2s_audio_pkg::CNT_ONE;
    localparam logic [CNT_W-1:0] WORD_CNT = i2s_audio_pkg::WORD_CNT;
    localparam logic [CNT_W-1:0] HALF_NARROW = i2s_audio_pkg::HALF_NARROW;
    localparam logic [CNT_W-1:0] HALF_WIDE = i2s_audio_pkg::HALF_WIDE;
    localparam logic [CNT_W-1:0] LAST_NARROW = i2s_audio_pkg::LAST_NARROW;
    localparam logic [CNT_W-1:0] LAST_WIDE = i2s_audio_pkg::LAST_WIDE;
    localparam i2s_audio_pkg::port_mode_t MODE_OFF = i2s_audio_pkg::MODE_OFF;
    localparam i2s_audio_pkg::port_mode_t MODE_MASTER = i2s_audio_pkg::MODE_MASTER;
    localparam i2s_audio_pkg::port_mode_t MODE_SLAVE = i2s_audio_pkg::MODE_SLAVE;

    i2s_audio_pkg::port_mode_t mode_reg, mode_next;
    logic isMaster, active;
    // Divider and generated clock
    logic [15:0] acc_reg, acc_next;
    logic bclk_reg, bclk_next, tick;
    logic [16:0] accSum;
    logic [CNT_W-1:0] bitCnt_reg, bitCnt_next, lastBit, halfBit;
    logic wsOut_reg, wsOut_next;
    // Pin synchronisers and filtered levels
    logic [SYNC_STAGES-1:0] bclkS_reg, wsS_reg, sdiS_reg;
    logic bclkL_reg, wsL_reg, sdiL_reg, bclkF, wsF, sdiF;
    // Event pipeline
    logic [RX_ALIGN-1:0] riseDly_reg, wsDly_reg;
    logic rise, fall, rxRise, wsCur, wsRx;
    // Transmit path
    logic wsSeen_reg, wsSeen_next, wsTx_reg, wsTx_next;
    logic [W-1:0] shOut_reg, shOut_next, right_reg, right_next;
    logic [CNT_W-1:0] txCnt_reg, txCnt_next;
    logic sdo_reg, sdo_next, newHalf;
    logic [FW-1:0] word;
    // Receive path
    logic wsRxL_reg, wsRxL_next;
    logic [W-1:0] rxSh_reg, rxSh_next, rxLeft_reg, rxLeft_next;
    logic [CNT_W-1:0] rxCnt_reg, rxCnt_next;
    logic [31:0] rxData_reg, rxData_next;
    logic rxValid_reg, rxValid_next;

    sample_stream_if #(.WIDTH(FW)) fillS ();
    sample_stream_if #(.WIDTH(FW)) drainS ();

    // Filtered pin level: change only once stages two and three agree
    function automatic logic settle(input logic [SYNC_STAGES-1:0] s, input logic held);
        settle = (s[1] == s[2]) ? s[2] : held;
    endfunction

    // Outgoing sample pairs buffered ahead of the shifter
    assign fillS.valid = txValid;
    assign fillS.data = txData;
    assign txReady = fillS.ready;

    sample_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) txFifo (
        .clk(clk),
        .nrst(nrst),
        .wr(fillS),
        .rd(drainS)
    );

    // Mode selection
    always_comb begin
        if (pcmSelect) begin
            mode_next = MODE_OFF; // R12
        end else if (masterMode) begin
            mode_next = MODE_MASTER;
        end else begin
            mode_next = MODE_SLAVE;
        end
    end
    assign isMaster = (mode_reg == MODE_MASTER);
    assign active = (mode_reg != MODE_OFF);

    // Fractional divider: each overflow is one bit clock half period
    assign accSum = {1'b0, acc_reg} + {1'b0, divN}; // R9
    assign tick = isMaster && (accSum >= {1'b0, divM});
    assign lastBit = wideFrame ? LAST_WIDE : LAST_NARROW; // R7 R8
    assign halfBit = wideFrame ? HALF_WIDE : HALF_NARROW;
    always_comb begin
        acc_next = '0;
        bclk_next = 1'b0;
        bitCnt_next = CNT_ZERO;
        wsOut_next = 1'b0;
        if (isMaster) begin
            acc_next = tick ? 16'(accSum - {1'b0, divM}) : accSum[15:0];
            bclk_next = tick ? ~bclk_reg : bclk_reg; // R11
            bitCnt_next = bitCnt_reg;
            wsOut_next = wsOut_reg;
            if (tick && bclk_reg) begin
                bitCnt_next = (bitCnt_reg == lastBit) ? CNT_ZERO : bitCnt_reg + CNT_ONE;
                wsOut_next = (bitCnt_next >= halfBit); // R5
            end
        end
    end

    // Filtered pin levels: clock and select for slave mode, data for both modes
    assign bclkF = settle(bclkS_reg, bclkL_reg); // R10
    assign wsF = settle(wsS_reg, wsL_reg);
    assign sdiF = settle(sdiS_reg, sdiL_reg);

    // Unified edge events for both modes
    always_comb begin
        if (isMaster) begin
            rise = tick & ~bclk_reg;
            fall = tick & bclk_reg;
            wsCur = wsOut_reg;
            rxRise = riseDly_reg[RX_ALIGN-1];
            wsRx = wsDly_reg[RX_ALIGN-1];
        end else begin
            rise = active & bclkF & ~bclkL_reg;
            fall = active & ~bclkF & bclkL_reg;
            wsCur = wsF;
            rxRise = rise;
            wsRx = wsF;
        end
    end

    // Transmit: word loads on the falling edge after a select change
    assign newHalf = fall && (wsSeen_reg != wsTx_reg); // R4
    assign drainS.ready = newHalf && !wsSeen_reg;
    assign word = drainS.valid ? drainS.data : '0;
    always_comb begin
        wsSeen_next = rise ? wsCur : wsSeen_reg;
        wsTx_next = wsTx_reg;
        shOut_next = shOut_reg;
        right_next = right_reg;
        txCnt_next = txCnt_reg;
        sdo_next = active ? sdo_reg : 1'b0;
        if (newHalf) begin
            wsTx_next = wsSeen_reg;
            txCnt_next = CNT_ONE;
            if (!wsSeen_reg) begin
                sdo_next = word[FW-1]; // R3 R5
                shOut_next = {word[FW-2:W], 1'b0};
                right_next = word[W-1:0];
            end else begin
                sdo_next = right_reg[W-1];
                shOut_next = {right_reg[W-2:0], 1'b0};
            end
        end else if (fall) begin
            if (txCnt_reg < WORD_CNT) begin
                sdo_next = shOut_reg[W-1]; // R6
                shOut_next = {shOut_reg[W-2:0], 1'b0};
                txCnt_next = txCnt_reg + CNT_ONE;
            end else begin
                sdo_next = 1'b0; // R13
            end
        end
    end

    // Receive: capture on rising edges, ignore bits past the word
    always_comb begin
        wsRxL_next = wsRxL_reg;
        rxSh_next = rxSh_reg;
        rxLeft_next = rxLeft_reg;
        rxCnt_next = rxCnt_reg;
        rxData_next = rxData_reg;
        rxValid_next = 1'b0;
        if (rxRise) begin
            // The LSB of a full half lands on the rise that sees the select change
            if (rxCnt_reg < WORD_CNT) begin
                rxSh_next = {rxSh_reg[W-2:0], sdiF}; // R6 R3
                rxCnt_next = rxCnt_reg + CNT_ONE;
            end
            if (wsRx != wsRxL_reg) begin
                wsRxL_next = wsRx;
                rxCnt_next = CNT_ZERO;
                if (wsRx) begin
                    rxLeft_next = rxSh_next; // R5
                end else begin
                    rxData_next = {rxLeft_reg, rxSh_next};
                    rxValid_next = 1'b1;
                end
            end
        end
    end

    // State registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= MODE_OFF;
            acc_reg <= '0;
            bclk_reg <= 1'b0;
            bitCnt_reg <= CNT_ZERO;
            wsOut_reg <= 1'b0;
            bclkS_reg <= '0;
            wsS_reg <= '0;
            sdiS_reg <= '0;
            bclkL_reg <= 1'b0;
            wsL_reg <= 1'b0;
            sdiL_reg <= 1'b0;
            riseDly_reg <= '0;
            wsDly_reg <= '0;
            wsSeen_reg <= 1'b0;
            wsTx_reg <= 1'b0;
            shOut_reg <= '0;
            right_reg <= '0;
            txCnt_reg <= WORD_CNT;
            sdo_reg <= 1'b0;
            wsRxL_reg <= 1'b0;
            rxSh_reg <= '0;
            rxLeft_reg <= '0;
            rxCnt_reg <= WORD_CNT;
            rxData_reg <= '0;
            rxValid_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            acc_reg <= acc_next;
            bclk_reg <= bclk_next;
            bitCnt_reg <= bitCnt_next;
            wsOut_reg <= wsOut_next;
            bclkS_reg <= {bclkS_reg[SYNC_STAGES-2:0], audioBitClockIn};
            wsS_reg <= {wsS_reg[SYNC_STAGES-2:0], channelSelectIn};
            sdiS_reg <= {sdiS_reg[SYNC_STAGES-2:0], serialAudioIn};
            bclkL_reg <= bclkF;
            wsL_reg <= wsF;
            sdiL_reg <= sdiF;
            riseDly_reg <= {riseDly_reg[RX_ALIGN-2:0], rise};
            wsDly_reg <= {wsDly_reg[RX_ALIGN-2:0], wsOut_reg};
            wsSeen_reg <= wsSeen_next;
            wsTx_reg <= wsTx_next;
            shOut_reg <= shOut_next;
            right_reg <= right_next;
            txCnt_reg <= txCnt_next;
            sdo_reg <= sdo_next;
            wsRxL_reg <= wsRxL_next;
            rxSh_reg <= rxSh_next;
            rxLeft_reg <= rxLeft_next;
            rxCnt_reg <= rxCnt_next;
            rxData_reg <= rxData_next;
            rxValid_reg <= rxValid_next;
        end
    end

    // Pin drivers: enables low only while mastering the link
    assign audioBitClockOut = bclk_reg; // R1
    assign audioBitClockOe_n = ~isMaster; // R1 R12
    assign channelSelectOut = wsOut_reg;
    assign channelSelectOe_n = ~isMaster;
    assign serialAudioOut = sdo_reg; // R2
    assign rxData = rxData_reg;
    assign rxValid = rxValid_reg;
endmodule

//--- testbench/i2s_audio_port_monitor.sv
// Pin-level checker for the serial audio port
`timescale 1ns/1ps
module i2s_audio_port_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic masterMode,
    input wire logic pcmSelect,
    input wire logic wideFrame,
    input wire logic audioBitClockOut,
    input wire logic audioBitClockOe_n,
    input wire logic channelSelectOut,
    input wire logic channelSelectOe_n,
    input wire logic serialAudioOut,
    input wire logic rxValid
);
    logic run;
    logic seen_reg;
    logic [5:0] fallCnt_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    assign run = masterMode && !pcmSelect && !audioBitClockOe_n;
    // Bit clock falls since the last select change, valid after one full half
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fallCnt_reg <= 6'h00;
            seen_reg <= 1'b0;
        end else if (!run) begin
            seen_reg <= 1'b0;
        end else if ($changed(channelSelectOut)) begin
            fallCnt_reg <= 6'h00;
            seen_reg <= 1'b1;
        end else if ($fell(audioBitClockOut)) begin
            fallCnt_reg <= fallCnt_reg + 6'h01;
        end
    end
    // One bit clock level lasts two to four clocks, whatever the divider jitter
    sequence s_half(bit lvl);
        (audioBitClockOut == lvl) [*2] ##[1:3] (audioBitClockOut != lvl);
    endsequence
    // Mode settled for long enough to reach the enables
    sequence s_settled(bit m);
        (masterMode == m && !pcmSelect) [*3];
    endsequence
    chk_master_oe: assert property (s_settled(1'b1) |-> !audioBitClockOe_n && !channelSelectOe_n)
        else $error("clock or select not driven in master mode");
    chk_slave_oe: assert property (s_settled(1'b0) |-> audioBitClockOe_n && channelSelectOe_n)
        else $error("clock or select driven in slave mode");
    chk_pcm_idle: assert property (pcmSelect [*3] |-> audioBitClockOe_n && channelSelectOe_n && !serialAudioOut)
        else $error("pins not released while voice function selected");
    chk_data_fall: assert property (run && $changed(serialAudioOut) |-> $fell(audioBitClockOut))
        else $error("data changed away from a bit clock fall");
    chk_select_fall: assert property (run && $changed(channelSelectOut) |-> $fell(audioBitClockOut))
        else $error("select changed away from a bit clock fall");
    chk_half_len: assert property (run && seen_reg && $changed(channelSelectOut) |-> fallCnt_reg == (wideFrame ? 6'h18 : 6'h0f))
        else $error("wrong number of bit periods in a half frame");
    chk_tail_zero: assert property (run && seen_reg && fallCnt_reg > 6'h10 |-> !serialAudioOut)
        else $error("nonzero data after the sixteenth bit");
    chk_duty_high: assert property (run && $rose(audioBitClockOut) |-> s_half(1'b1))
        else $error("bit clock high time out of range");
    chk_duty_low: assert property (run && $fell(audioBitClockOut) |-> s_half(1'b0))
        else $error("bit clock low time out of range");
    chk_rx_pulse: assert property (rxValid |=> !rxValid)
        else $error("receive strobe longer than one clock");
endmodule

bind i2s_audio_port i2s_audio_port_monitor u_i2s_audio_port_monitor (
    .clk(clk), .nrst(nrst), .masterMode(masterMode), .pcmSelect(pcmSelect),
    .wideFrame(wideFrame), .audioBitClockOut(audioBitClockOut),
    .audioBitClockOe_n(audioBitClockOe_n), .channelSelectOut(channelSelectOut),
    .channelSelectOe_n(channelSelectOe_n), .serialAudioOut(serialAudioOut), .rxValid(rxValid)
);

//--- testbench/audio_codec_model.sv
// Behavioural far-end codec: makes clocks when asked, captures and sends frames
`timescale 1ns/1ps
module audio_codec_model #(
    parameter int HALF_NS = 600
) (
    input wire logic genClk,
    input wire logic devBclk,
    input wire logic devWs,
    input wire logic devOut,
    input wire logic [31:0] sendWord,
    output logic bclk,
    output logic ws,
    output logic sdIn,
    output logic [31:0] gotFrame,
    output logic gotTick
);
    logic lastR = 1'b0;
    logic lastF = 1'b0;
    logic [15:0] sh = 16'h0000;
    logic [15:0] lft = 16'h0000;
    logic [15:0] cur = 16'h0000;
    int rk = 0;
    int fk = 0;
    initial begin
        {bclk, ws, sdIn, gotTick, gotFrame} = '0;
    end
    // Whole frames of 32 bits, clock still while not generating
    always begin
        wait (genClk);
        for (int b = 0; b < 32; b++) begin
            #HALF_NS bclk = 1'b0;
            ws = (b >= 16);
            #HALF_NS bclk = 1'b1;
        end
    end
    // Capture on rising edges, sixteen bits a half, extra bits dropped
    always @(posedge devBclk) begin
        if (rk < 16) sh = {sh[14:0], devOut};
        rk++;
        if (devWs != lastR) begin
            rk = 0;
            lastR = devWs;
            if (devWs) begin
                lft = sh;
            end else begin
                gotFrame = {lft, sh};
                gotTick = ~gotTick;
            end
        end
    end
    // Send after falling edges, junk on bit periods beyond the word
    always @(negedge devBclk) begin
        #1;
        fk++;
        sdIn = (fk <= 16) ? cur[16 - fk] : ~sdIn;
        if (devWs != lastF) begin
            lastF = devWs;
            fk = 0;
            cur = devWs ? sendWord[15:0] : sendWord[31:16];
        end
    end
endmodule

//--- testbench/tb_i2s_audio_port.sv
// Self-checking bench for the serial audio port against a codec model
`timescale 1ns/1ps
module tb_i2s_audio_port;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic masterMode = 1'b1;
    logic pcmSelect = 1'b0;
    logic wideFrame = 1'b0;
    logic genClk = 1'b0;
    logic txValid = 1'b0;
    logic [15:0] divN = i2s_audio_pkg::DIV_N_NARROW;
    logic [15:0] divM = i2s_audio_pkg::DIV_M_NARROW;
    logic [31:0] txData = '0;
    logic [31:0] sendWord = '0;
    logic bclkOut, bclkOe_n, wsOut, wsOe_n, sdOut, bclkM, wsM, sdIn, txReady, rxValid, gotTick;
    logic bclkW, wsW, collect;
    logic [31:0] rxData, gotFrame;
    logic [31:0] gotQ[$];
    logic [31:0] expQ[$];
    int n_fail = 0;
    int checks = 0;
    always #50 clk = ~clk;
    // Wire levels from whichever side drives
    assign bclkW = bclkOe_n ? bclkM : bclkOut;
    assign wsW = wsOe_n ? wsM : wsOut;
    i2s_audio_port u_i2s_audio_port (
        .clk(clk), .nrst(nrst), .masterMode(masterMode), .pcmSelect(pcmSelect),
        .wideFrame(wideFrame), .divN(divN), .divM(divM), .audioBitClockIn(bclkW),
        .audioBitClockOut(bclkOut), .audioBitClockOe_n(bclkOe_n), .channelSelectIn(wsW),
        .channelSelectOut(wsOut), .channelSelectOe_n(wsOe_n), .serialAudioOut(sdOut),
        .serialAudioIn(sdIn), .txData(txData), .txValid(txValid), .txReady(txReady),
        .rxData(rxData), .rxValid(rxValid)
    );
    audio_codec_model u_audio_codec_model (
        .genClk(genClk), .devBclk(bclkW), .devWs(wsW), .devOut(sdOut), .sendWord(sendWord),
        .bclk(bclkM), .ws(wsM), .sdIn(sdIn), .gotFrame(gotFrame), .gotTick(gotTick)
    );
    // Frames seen by the codec
    always @(gotTick) begin
        if (collect === 1'b1) gotQ.push_back(gotFrame);
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (exp !== got) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask
    task automatic test_done;
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic restart(input logic m, input logic w, input logic g);
        nrst = 1'b0;
        collect = 1'b0;
        masterMode = m;
        wideFrame = w;
        genClk = g;
        divN = w ? i2s_audio_pkg::DIV_N_WIDE : i2s_audio_pkg::DIV_N_NARROW;
        divM = w ? i2s_audio_pkg::DIV_M_WIDE : i2s_audio_pkg::DIV_M_NARROW;
        sendWord = $urandom;
        tick(10);
        nrst = 1'b1;
        tick(1);
    endtask
    // Valid stays up between back-to-back pushes
    task automatic push(input logic [31:0] w, input int lim, output logic acc);
        txData = w;
        txValid = 1'b1;
        acc = 1'b0;
        for (int i = 0; i < lim && !acc; i++) begin
            @(posedge clk);
            acc = txReady;
            #5;
        end
    endtask
    // Expected words in order, then an empty frame, and the codec's sent word in rxData
    task automatic wait_compare(input int n);
        for (int i = 0; i < 8000 && gotQ.size() < n; i++) tick(1);
        if (gotQ.size() < n) begin
            check("frame count", 32'(n), 32'(gotQ.size()));
            test_done;
        end else begin
            while (gotQ.size() > 0 && gotQ[0] !== expQ[0]) void'(gotQ.pop_front());
            foreach (expQ[i]) check("frame", expQ[i], gotQ[i]);
            check("idle frame", 32'h0, gotQ[expQ.size()]);
            check("rxData", sendWord, rxData);
            gotQ.delete();
            expQ.delete();
        end
    endtask
    task automatic stream(input logic m, input logic w, input logic g, input logic [31:0] c);
        logic acc;
        logic [31:0] v;
        restart(m, w, g);
        collect = 1'b1;
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? c : ($urandom | 32'h0001_0001);
            push(v, 50, acc);
            check("accepted", 32'h1, {31'h0, acc});
            expQ.push_back(v);
        end
        txValid = 1'b0;
        wait_compare(12);
    endtask
    initial begin
        logic acc;
        logic [31:0] v;
        int n;
        void'($urandom(32'hefb4e6e0));
        stream(1'b1, 1'b0, 1'b0, 32'h8000_0001);
        stream(1'b1, 1'b1, 1'b0, 32'hffff_ffff);
        stream(1'b0, 1'b0, 1'b1, 32'h0001_8000);
        pcmSelect = 1'b1;
        restart(1'b1, 1'b0, 1'b0);
        tick(3);
        check("pcm pins", 32'h6, {29'h0, bclkOe_n, wsOe_n, sdOut});
        n = 0;
        for (int k = 0; k < 12; k++) begin
            v = $urandom | 32'h0001_0001;
            push(v, 1, acc);
            if (acc) begin
                n++;
                expQ.push_back(v);
            end
        end
        txValid = 1'b0;
        check("words held", 32'h8, 32'(n));
        check("txReady full", 32'h0, {31'h0, txReady});
        collect = 1'b1;
        pcmSelect = 1'b0;
        wait_compare(14);
        test_done;
    end
endmodule
